// ---- shared/ssr_pkg.sv ----
// Package for the synchronous serial receiver: register map, fields, timing
package ssr_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, word aligned)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DATA   = 4'h8;
  localparam logic [3:0] ADDR_BAUD   = 4'hC;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_PORT_EN  = 0;
  localparam int CTRL_SYNC     = 1;
  localparam int CTRL_CLK_SRC  = 2;
  localparam int CTRL_NINE     = 3;
  localparam int CTRL_SINGLE   = 4;
  localparam int CTRL_CONT     = 5;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int STAT_PENDING  = 0;
  localparam int STAT_OVERRUN  = 1;
  localparam int STAT_NINTH    = 2;
  localparam int STAT_LEVEL_LO = 4;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int          CHAR_W      = 9;
  localparam int          FIFO_DEPTH  = 2;
  localparam logic [3:0]  BITS_EIGHT  = 4'h8;
  localparam logic [3:0]  BITS_NINE   = 4'h9;
  localparam logic [15:0] BAUD_RESET  = 16'h0004;
  localparam logic [5:0]  CTRL_RESET  = 6'h00;

  typedef enum logic [1:0] {
    SSR_IDLE  = 2'b00,
    SSR_SHIFT = 2'b01,
    SSR_DONE  = 2'b10
  } ssr_state_t;

endpackage : ssr_pkg

// ---- hw/ssr_sync.sv ----
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ssr_sync (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  // Asynchronous level and its safe copy
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_ff;

  // First stage is read by the second stage only
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      meta_ff  <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule : ssr_sync

// ---- hw/ssr_receiver.sv ----
// Synchronous serial receiver with Avalon-MM register slave
//
// How it works
// - Master receive mode turns the data pin driver off; pin only listens.
// - Setting single or continuous receive enable starts reception in sync mode.
// - Single receive alone: master makes one character worth of clocks, then stops.
// - Single receive enable clears itself when one character is complete.
// - Continuous receive: clocks run until software clears the enable; here an overrun also stops them.
// - Clearing continuous mid character stops clock at once, drops partial character.
// - Both enables set: single clears after first character, continuous governs.
// - Data sampled on trailing (falling) clock edge, shifted into shift register.
// - Complete character sets pending flag and enters two deep FIFO.
// - Data register reads low eight bits of oldest unread character.
// - Pending flag stays high while FIFO holds any unread character.
// - Slave mode takes clock from clock pin with its driver off.
// - Data changes on leading edge, valid at trailing edge, one bit per cycle.
// - Third character arriving with FIFO full sets overrun flag.
// - On overrun FIFO kept intact, no more characters accepted until cleared.
// - Overrun not writable; single mode overrun clears on data register read.
// - Continuous mode overrun clears by clearing continuous or port enable.
// - Nine bit select shifts nine bits per character instead of eight.
// - Ninth bit flag shows bit nine of oldest unread character.
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module ssr_receiver (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Data line pin
  input  wire logic        data_line_pin_in,
  output logic             data_line_pin_out,
  output logic             data_line_pin_oe_out,
  // Clock line pin
  input  wire logic        clock_line_pin_in,
  output logic             clock_line_pin_out,
  output logic             clock_line_pin_oe_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                           port_en_ff, sync_ff, clk_src_ff, nine_ff;
  logic                           single_ff, cont_ff;
  logic [15:0]                    baud_ff;
  logic [15:0]                    baud_cnt_ff;
  logic                           sck_ff;
  logic                           data_s, clk_s, clk_d_ff;
  ssr_pkg::ssr_state_t            state_ff;
  logic [3:0]                     bit_cnt_ff;
  logic [ssr_pkg::CHAR_W-1:0]     shift_ff;
  logic [ssr_pkg::CHAR_W-1:0]     fifo_mem [ssr_pkg::FIFO_DEPTH];
  logic [1:0]                     level_ff;
  logic                           overrun_ff, ovr_single_ff;
  logic                           ack_ff;
  logic                           master, active, fall_edge, char_done, pop;
  logic                           wr_ctrl, wr_baud, cont_clear;
  logic [3:0]                     char_bits;
  logic [5:0]                     nxt_ctrl;

  function automatic logic sel(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction : sel

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // One wait cycle per access keeps read data registered
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_ff;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read_in | avs_write_in) & ~ack_ff;
    end
  end

  assign wr_ctrl = avs_write_in & ~ack_ff & sel(avs_address_in, ssr_pkg::ADDR_CTRL)
                   & avs_byteenable_in[0];
  assign wr_baud = avs_write_in & ~ack_ff & sel(avs_address_in, ssr_pkg::ADDR_BAUD);
  assign pop     = avs_read_in & ~ack_ff & sel(avs_address_in, ssr_pkg::ADDR_DATA)
                   & (level_ff != 2'h0);

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in & ~ack_ff) begin
      case (avs_address_in)
        ssr_pkg::ADDR_CTRL: begin
          avs_readdata_out <= {26'h0, cont_ff, single_ff, nine_ff, clk_src_ff,
                               sync_ff, port_en_ff};
        end
        ssr_pkg::ADDR_STATUS: begin
          avs_readdata_out <= {26'h0, level_ff, 1'b0, fifo_mem[0][8], overrun_ff,
                               level_ff != 2'h0};
        end
        ssr_pkg::ADDR_DATA: begin
          avs_readdata_out <= {24'h0, fifo_mem[0][7:0]};
        end
        ssr_pkg::ADDR_BAUD: begin
          avs_readdata_out <= {16'h0, baud_ff};
        end
        default: begin
          avs_readdata_out <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  assign nxt_ctrl   = wr_ctrl ? avs_writedata_in[5:0]
                              : {cont_ff, single_ff, nine_ff, clk_src_ff, sync_ff, port_en_ff};
  assign cont_clear = cont_ff & ~nxt_ctrl[ssr_pkg::CTRL_CONT];

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      {cont_ff, single_ff, nine_ff, clk_src_ff, sync_ff, port_en_ff} <= ssr_pkg::CTRL_RESET;
    end else begin
      port_en_ff <= nxt_ctrl[ssr_pkg::CTRL_PORT_EN];
      sync_ff    <= nxt_ctrl[ssr_pkg::CTRL_SYNC];
      clk_src_ff <= nxt_ctrl[ssr_pkg::CTRL_CLK_SRC];
      nine_ff    <= nxt_ctrl[ssr_pkg::CTRL_NINE];
      cont_ff    <= nxt_ctrl[ssr_pkg::CTRL_CONT] & nxt_ctrl[ssr_pkg::CTRL_PORT_EN];
      // Hardware clear beats a software set arriving the same cycle
      single_ff  <= nxt_ctrl[ssr_pkg::CTRL_SINGLE] & nxt_ctrl[ssr_pkg::CTRL_PORT_EN]
                    & ~char_done;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      baud_ff <= ssr_pkg::BAUD_RESET;
    end else if (wr_baud) begin
      baud_ff <= avs_writedata_in[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Pins and clocking
  // ----------------------------------------------------------------
  ssr_sync u_sync_data (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .async_in (data_line_pin_in),
    .sync_out (data_s)
  );

  ssr_sync u_sync_clk (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .async_in (clock_line_pin_in),
    .sync_out (clk_s)
  );

  assign master    = port_en_ff & sync_ff & clk_src_ff;
  assign char_bits = nine_ff ? ssr_pkg::BITS_NINE : ssr_pkg::BITS_EIGHT;
  // Receive only while accepting; overrun holds the line still
  assign active    = port_en_ff & sync_ff & (single_ff | cont_ff) & ~overrun_ff;

  assign data_line_pin_out     = 1'b0;
  assign data_line_pin_oe_out  = 1'b0;
  assign clock_line_pin_out    = sck_ff;
  assign clock_line_pin_oe_out = master;

  // Baud generator: half period of baud_ff+1 cycles, idle high
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      baud_cnt_ff <= 16'h0000;
      sck_ff      <= 1'b1;
    end else if (!(master & active) | cont_clear) begin
      baud_cnt_ff <= 16'h0000;
      sck_ff      <= 1'b1;
    end else if (baud_cnt_ff >= baud_ff) begin
      baud_cnt_ff <= 16'h0000;
      sck_ff      <= ~sck_ff;
    end else begin
      baud_cnt_ff <= baud_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      clk_d_ff <= 1'b1;
    end else begin
      clk_d_ff <= master ? sck_ff : clk_s;
    end
  end

  // Trailing edge of the clock line (idle high, falls at mid cycle)
  assign fall_edge = clk_d_ff & ~(master ? sck_ff : clk_s);

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  assign char_done = (state_ff == ssr_pkg::SSR_SHIFT) & active & ~cont_clear & fall_edge
                     & (bit_cnt_ff == char_bits - 4'h1);

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state_ff   <= ssr_pkg::SSR_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= '0;
    end else begin
      case (state_ff)
        ssr_pkg::SSR_IDLE: begin
          bit_cnt_ff <= 4'h0;
          if (active) begin
            state_ff <= ssr_pkg::SSR_SHIFT;
          end
        end
        ssr_pkg::SSR_SHIFT: begin
          if (!active | cont_clear) begin
            state_ff <= ssr_pkg::SSR_IDLE;
          end else if (fall_edge) begin
            // LSB first: new bit enters at the top of the character
            shift_ff   <= nine_ff ? {data_s, shift_ff[8:1]}
                                  : {1'b0, data_s, shift_ff[7:1]};
            bit_cnt_ff <= char_done ? 4'h0 : bit_cnt_ff + 4'h1;
            if (char_done) begin
              state_ff <= ssr_pkg::SSR_DONE;
            end
          end
        end
        ssr_pkg::SSR_DONE: begin
          state_ff <= active ? ssr_pkg::SSR_SHIFT : ssr_pkg::SSR_IDLE;
        end
        default: begin
          state_ff <= ssr_pkg::SSR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // FIFO and overrun
  // ----------------------------------------------------------------
  // Character enters the FIFO one cycle after its last bit, in DONE
  always_ff @(posedge clock_in) begin
    if (!rst_b_in | !port_en_ff) begin
      level_ff    <= 2'h0;
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
    end else begin
      if (pop) begin
        fifo_mem[0] <= fifo_mem[1];
      end
      // A pop in the same cycle frees a slot, so a full FIFO still takes the character
      if (state_ff == ssr_pkg::SSR_DONE && (level_ff != 2'h2 || pop)) begin
        fifo_mem[(level_ff[0] & ~pop) | level_ff[1]] <= shift_ff;
        level_ff <= pop ? level_ff : level_ff + 2'h1;
      end else if (pop) begin
        level_ff <= level_ff - 2'h1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in | !port_en_ff) begin
      overrun_ff    <= 1'b0;
      ovr_single_ff <= 1'b0;
    end else if (state_ff == ssr_pkg::SSR_DONE && level_ff == 2'h2 && !pop) begin
      overrun_ff    <= 1'b1;
      ovr_single_ff <= ~cont_ff;
    end else if ((ovr_single_ff & pop) | (~ovr_single_ff & cont_clear)) begin
      overrun_ff    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  data_pin_off_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !data_line_pin_oe_out) else $error("data pin driven");
  single_clear_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    char_done && !wr_ctrl |=> !single_ff) else $error("single not cleared");
  cont_stop_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cont_clear && !single_ff |=> sck_ff && state_ff != ssr_pkg::SSR_DONE)
    else $error("clock kept after cont clear");
  pend_level_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    state_ff == ssr_pkg::SSR_DONE && level_ff == 2'h0 && port_en_ff |=> level_ff == 2'h1)
    else $error("char not queued");
  fifo_cap_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    level_ff <= 2'h2) else $error("fifo over depth");
  overrun_set_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    state_ff == ssr_pkg::SSR_DONE && level_ff == 2'h2 && !pop && port_en_ff
    |=> overrun_ff && level_ff == 2'h2) else $error("overrun missed");
  overrun_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    overrun_ff |-> !active) else $error("receiving during overrun");
  clk_drive_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    clock_line_pin_oe_out == master) else $error("clock pin drive wrong");
  pop_shift_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    pop && level_ff == 2'h2 && state_ff != ssr_pkg::SSR_DONE && port_en_ff
    |=> fifo_mem[0] == $past(fifo_mem[1]) && level_ff == 2'h1)
    else $error("pop failed");

endmodule : ssr_receiver

// ---- bench/ssr_far_end.sv ----
// Far-side synchronous serial device that feeds characters to the receiver
`timescale 1ns/1ps
module ssr_far_end (
  // Line side
  input  wire logic       line_clock_in,
  input  wire logic       master_mode_in,
  input  wire logic       frame_clr_in,
  // Character to send
  input  wire logic [8:0] word_in,
  input  wire logic [3:0] nbits_in,
  // Pins driven by this device
  output logic            data_out,
  output logic            sck_out,
  output logic            sck_oe_out
);
  int unsigned idx = 0;
  initial begin
    data_out   = 1'b1;
    sck_out    = 1'b1;
    sck_oe_out = 1'b0;
  end
  // ----------------------------------------------------------------
  // Master-clocked frames
  // ----------------------------------------------------------------
  always @(posedge frame_clr_in) begin
    idx      = 0;
    data_out = word_in[0];
  end
  // Next bit moves after the rising edge, so it is steady at the falling sample
  always @(posedge line_clock_in) begin
    if (master_mode_in) begin
      idx      = (idx + 1 >= nbits_in) ? 0 : idx + 1;
      data_out = word_in[idx];
    end
  end
  // ----------------------------------------------------------------
  // Own clock in slave mode, 125 ns period, only inside the frame
  // ----------------------------------------------------------------
  task automatic slave_frame(input logic [8:0] w, input int n);
    #3;
    sck_oe_out = 1'b1;
    for (int i = 0; i < n; i++) begin
      data_out = w[i];
      #62.5 sck_out = 1'b0;
      #62.5 sck_out = 1'b1;
    end
    data_out   = ~w[n-1];
    sck_oe_out = 1'b0;
  endtask : slave_frame
endmodule : ssr_far_end

// ---- bench/ssr_receiver_tb.sv ----
// Self-checking bench for the synchronous serial receiver
`timescale 1ns/1ps
module ssr_receiver_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clock_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [3:0]  addr     = 4'h0;
  logic        rd       = 1'b0;
  logic        wr       = 1'b0;
  logic [31:0] wdata    = 32'h0;
  logic        clr      = 1'b0;
  logic [8:0]  word     = 9'h000;
  logic [3:0]  nbits    = 4'h8;
  logic [31:0] rdata;
  logic [31:0] v;
  logic        wait_req;
  logic        dat_o;
  logic        dat_oe;
  logic        ck_o;
  logic        ck_oe;
  logic        far_d;
  logic        far_ck;
  logic        far_oe;
  logic        data_line;
  logic        clock_line;
  int          fail_count = 0;
  int          checked    = 0;
  int          falls      = 0;
  int          n;

  always #5 clock_in = ~clock_in;
  // Clock line has a pull-up, so it rests high when nobody drives it
  assign data_line  = dat_oe ? dat_o : far_d;
  assign clock_line = ck_oe ? ck_o : (far_oe ? far_ck : 1'b1);
  always @(negedge ck_o) if (ck_oe === 1'b1) falls++;

  ssr_receiver uut (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
    .data_line_pin_in(data_line), .data_line_pin_out(dat_o), .data_line_pin_oe_out(dat_oe),
    .clock_line_pin_in(clock_line), .clock_line_pin_out(ck_o), .clock_line_pin_oe_out(ck_oe));
  ssr_far_end far (
    .line_clock_in(clock_line), .master_mode_in(ck_oe), .frame_clr_in(clr), .word_in(word),
    .nbits_in(nbits), .data_out(far_d), .sck_out(far_ck), .sck_oe_out(far_oe));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask : check

  // Request held until waitrequest is sampled low; released right after
  task automatic bus(input logic is_wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_in);
    rd    <= ~is_wr;
    wr    <= is_wr;
    addr  <= a;
    wdata <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge clock_in);
      if (wait_req === 1'b0) break;
    end
    v = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k == 50) begin
      fail_count++;
      end_of_test();
    end
  endtask : bus

  task automatic chk_rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(v, exp);
  endtask : chk_rd

  task automatic wait_bit(input logic [3:0] a, input int b, input logic val);
    int k;
    for (k = 0; k < 400; k++) begin
      bus(1'b0, a, 32'h0);
      if (v[b] === val) break;
    end
    if (k == 400) begin
      fail_count++;
      end_of_test();
    end
  endtask : wait_bit

  task automatic start(input logic [8:0] w, input logic [3:0] nb, input logic [31:0] c);
    @(posedge clock_in);
    word  <= w;
    nbits <= nb;
    @(posedge clock_in);
    clr   <= 1'b1;
    @(posedge clock_in);
    clr   <= 1'b0;
    falls = 0;
    bus(1'b1, ssr_pkg::ADDR_CTRL, c & 32'h0000_000F);
    bus(1'b1, ssr_pkg::ADDR_CTRL, c);
  endtask : start

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk_rd(ssr_pkg::ADDR_CTRL, 32'h0);
    chk_rd(ssr_pkg::ADDR_STATUS, 32'h0);
    chk_rd(ssr_pkg::ADDR_BAUD, {16'h0, ssr_pkg::BAUD_RESET});
    bus(1'b1, 4'h2, 32'hFF);
    chk_rd(4'h2, 32'h0);
    chk_rd(ssr_pkg::ADDR_CTRL, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_single;
    start(9'h0A5, 4'h8, 32'h17);
    wait_bit(ssr_pkg::ADDR_STATUS, ssr_pkg::STAT_PENDING, 1'b1);
    check(32'(dat_oe), 32'h0);
    check(32'(ck_oe), 32'h1);
    repeat (100) @(posedge clock_in);
    check(falls, 32'h8);
    chk_rd(ssr_pkg::ADDR_CTRL, 32'h7);
    chk_rd(ssr_pkg::ADDR_STATUS, 32'h11);
    chk_rd(ssr_pkg::ADDR_DATA, 32'hA5);
    chk_rd(ssr_pkg::ADDR_STATUS, 32'h0);
    $display("test single done");
  endtask : t_single

  task automatic t_nine;
    start(9'h1C3, 4'h9, 32'h1F);
    wait_bit(ssr_pkg::ADDR_CTRL, ssr_pkg::CTRL_SINGLE, 1'b0);
    check(falls, 32'h9);
    start(9'h03C, 4'h9, 32'h1F);
    wait_bit(ssr_pkg::ADDR_CTRL, ssr_pkg::CTRL_SINGLE, 1'b0);
    chk_rd(ssr_pkg::ADDR_STATUS, 32'h25);
    chk_rd(ssr_pkg::ADDR_DATA, 32'hC3);
    chk_rd(ssr_pkg::ADDR_STATUS, 32'h11);
    chk_rd(ssr_pkg::ADDR_DATA, 32'h3C);
    $display("test nine bit done");
  endtask : t_nine

  task automatic t_ovr_single;
    for (int i = 1; i < 4; i++) begin
      start(9'(i * 8'h11), 4'h8, 32'h17);
      wait_bit(i < 3 ? ssr_pkg::ADDR_CTRL : ssr_pkg::ADDR_STATUS,
               i < 3 ? ssr_pkg::CTRL_SINGLE : ssr_pkg::STAT_OVERRUN, i == 3);
    end
    chk_rd(ssr_pkg::ADDR_STATUS, 32'h23);
    bus(1'b1, ssr_pkg::ADDR_STATUS, 32'h0);
    chk_rd(ssr_pkg::ADDR_STATUS, 32'h23);
    chk_rd(ssr_pkg::ADDR_DATA, 32'h11);
    chk_rd(ssr_pkg::ADDR_STATUS, 32'h11);
    chk_rd(ssr_pkg::ADDR_DATA, 32'h22);
    $display("test overrun single done");
  endtask : t_ovr_single

  task automatic t_ovr_cont;
    start(9'h05A, 4'h8, 32'h37);
    wait_bit(ssr_pkg::ADDR_CTRL, ssr_pkg::CTRL_SINGLE, 1'b0);
    chk_rd(ssr_pkg::ADDR_CTRL, 32'h27);
    wait_bit(ssr_pkg::ADDR_STATUS, ssr_pkg::STAT_OVERRUN, 1'b1);
    check(32'(falls >= 24), 32'h1);
    n = falls;
    repeat (200) @(posedge clock_in);
    check(falls, n);
    chk_rd(ssr_pkg::ADDR_STATUS, 32'h23);
    chk_rd(ssr_pkg::ADDR_DATA, 32'h5A);
    chk_rd(ssr_pkg::ADDR_STATUS, 32'h13);
    bus(1'b1, ssr_pkg::ADDR_CTRL, 32'h07);
    chk_rd(ssr_pkg::ADDR_STATUS, 32'h11);
    chk_rd(ssr_pkg::ADDR_DATA, 32'h5A);
    $display("test overrun continuous done");
  endtask : t_ovr_cont

  task automatic t_abort;
    start(9'h0FF, 4'h8, 32'h27);
    for (n = 0; n < 400 && falls < 3; n++) @(posedge clock_in);
    check(32'(falls >= 3), 32'h1);
    bus(1'b1, ssr_pkg::ADDR_CTRL, 32'h07);
    n = falls;
    repeat (100) @(posedge clock_in);
    check(falls, n);
    chk_rd(ssr_pkg::ADDR_STATUS, 32'h0);
    $display("test abort done");
  endtask : t_abort

  task automatic t_slave;
    bus(1'b1, ssr_pkg::ADDR_CTRL, 32'h13);
    far.slave_frame(9'h096, 8);
    wait_bit(ssr_pkg::ADDR_STATUS, ssr_pkg::STAT_PENDING, 1'b1);
    check(32'(ck_oe), 32'h0);
    chk_rd(ssr_pkg::ADDR_CTRL, 32'h3);
    chk_rd(ssr_pkg::ADDR_DATA, 32'h96);
    $display("test slave done");
  endtask : t_slave

  initial begin
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_single();
    t_nine();
    t_ovr_single();
    t_ovr_cont();
    t_abort();
    t_slave();
    end_of_test();
  end
endmodule : ssr_receiver_tb
